/* logic/dpr_pkg.sv */
// shared constants, mode encodings and helpers for the dual-port cell memory
package dpr_pkg;

	// total bit cells in the array
	localparam int unsigned DPR_CELLS = 4096;
	// widest data lane that a port may be given
	localparam int unsigned DPR_MAX_WIDTH = 16;
	// read data value after reset, cut to the port width where used
	localparam logic [15:0] DPR_OUT_RST = 16'h0000;
	// cell contents after reset
	localparam logic [4095:0] DPR_CELL_RST = '0;

	// what a port is allowed to do
	typedef enum logic [1:0] {
		DPR_MODE_RW = 2'b00, // read and write
		DPR_MODE_RO = 2'b01, // read only, write enable ignored
		DPR_MODE_WO = 2'b10  // write only, reads ignored; output only mirrors writes
	} dpr_mode_type;

	// legal lane widths
	function automatic bit dpr_width_ok(input int unsigned w);
		return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16);
	endfunction : dpr_width_ok

	// address bits needed so a port of width w spans every cell
	function automatic int unsigned dpr_addr_w(input int unsigned w);
		return $clog2(DPR_CELLS / w);
	endfunction : dpr_addr_w

	// low w bits set
	function automatic logic [15:0] dpr_lane_mask(input int unsigned w);
		return 16'((32'h1 << w) - 32'h1);
	endfunction : dpr_lane_mask

	// word of width w at word address a, in the low bits
	function automatic logic [15:0] dpr_slice(input logic [4095:0] c, input int unsigned a,
			input int unsigned w);
		return 16'(c >> (a * w)) & dpr_lane_mask(w);
	endfunction : dpr_slice

endpackage : dpr_pkg

/* logic/dpr_port.sv */
// one access port: samples its inputs, builds write lanes and holds its output word
module dpr_port #(
	parameter int unsigned WIDTH = 16,
	parameter dpr_pkg::dpr_mode_type MODE = dpr_pkg::DPR_MODE_RW
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// user side
	input wire logic en,
	input wire logic we,
	input wire logic [dpr_pkg::dpr_addr_w(WIDTH)-1:0] addr,
	input wire logic [WIDTH-1:0] write_data_in,
	output logic [WIDTH-1:0] read_data,
	// memory side
	input wire logic [4095:0] cells,
	output logic [4095:0] wr_mask,
	output logic [4095:0] wr_bits
);
	import dpr_pkg::*;

	// refuse widths the lane arithmetic cannot serve
	if (!dpr_width_ok(WIDTH)) begin : g_bad_width
		$error("dpr_port: width must be 1, 2, 4, 8 or 16");
	end

	typedef struct packed {
		logic [WIDTH-1:0] rdata; // word last read or written back
	} dpr_port_state_type;

	dpr_port_state_type st_ff;
	dpr_port_state_type nxt_st;
	logic do_write; // write taken this edge
	logic do_read; // read taken this edge
	logic [WIDTH-1:0] rd_word; // addressed word before the edge

	// decode the operation; a read-only port treats a write as a read
	always_comb begin
		do_write = en && we && (MODE != DPR_MODE_RO); // R11 R2
		do_read = en && !do_write && (MODE != DPR_MODE_WO); // R11 R2
		rd_word = WIDTH'(dpr_slice(cells, 32'(addr), WIDTH)); // R3
		wr_mask = '0;
		wr_bits = '0;
		if (do_write) begin
			// lanes are scaled by width so any width spans all cells
			wr_mask = 4096'(dpr_lane_mask(WIDTH)) << (32'(addr) * WIDTH); // R15 R4
			wr_bits = 4096'(write_data_in) << (32'(addr) * WIDTH); // R4
		end
	end

	// next output word: mirror on write, contents on read, else hold
	always_comb begin
		nxt_st = st_ff;
		if (do_write) begin
			nxt_st.rdata = write_data_in; // R6 R4
		end else if (do_read) begin
			nxt_st.rdata = rd_word; // R6 R3
		end
	end

	// single edge register; output only moves here, never from addr directly
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff <= '{rdata: WIDTH'(DPR_OUT_RST)};
		end else begin
			st_ff <= nxt_st; // R5 R9 R7 R10
		end
	end

	assign read_data = st_ff.rdata;

	// output mirrors the written word one edge later
	write_back_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
		do_write |=> read_data == $past(write_data_in))
		else $error("write back word wrong");
	// output shows the addressed contents after a read
	read_through_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
		do_read |=> read_data == $past(rd_word))
		else $error("read through word wrong");
	// a disabled port keeps its output
	idle_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
		!en |=> $stable(read_data))
		else $error("idle port output moved");
	// a write touches exactly one word of cells
	lane_width_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
		$countones(wr_mask) == (do_write ? WIDTH : 0))
		else $error("write lane width wrong");

endmodule : dpr_port

/* logic/dpr_ram.sv */
// dual-port bit cell memory: shared array and two independent access ports
//
// How it works
// R1: 4096 cells, both ports read and write
// R2: each port rw, read-only or write-only, own width
// R3: read registers the addressed contents at the edge, then shows them
// R4: write stores data and mirrors it out
// R5: all port inputs sampled on port clock
// R6: output read-through, or write-back when writing
// R7: no combinational path address to output
// R8: ports independent, no arbitration
// R9: one edge completes a read or write
// R10: output glitch-free, held until next operation
// R11: enable and write enable select the operation
// R12: enable low: no operation, output held
// R13: users avoid same-cell writes from both ports
// R14: same-cell read during write: write wins, read undefined
// R15: widths 1, 2, 4, 8 or 16, address scaled to cells
module dpr_ram #(
	parameter int unsigned A_WIDTH = 16,
	parameter int unsigned B_WIDTH = 16,
	parameter dpr_pkg::dpr_mode_type A_MODE = dpr_pkg::DPR_MODE_RW,
	parameter dpr_pkg::dpr_mode_type B_MODE = dpr_pkg::DPR_MODE_RW
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// port a
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [dpr_pkg::dpr_addr_w(A_WIDTH)-1:0] a_addr,
	input wire logic [A_WIDTH-1:0] a_write_data_in,
	output logic [A_WIDTH-1:0] a_read_data,
	// port b
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [dpr_pkg::dpr_addr_w(B_WIDTH)-1:0] b_addr,
	input wire logic [B_WIDTH-1:0] b_write_data_in,
	output logic [B_WIDTH-1:0] b_read_data
);
	import dpr_pkg::*;

	// each port's words must tile the whole array exactly, or some cells
	// would be out of reach of that port
	if ((32'd1 << dpr_addr_w(A_WIDTH)) * A_WIDTH != DPR_CELLS) begin : g_bad_span_a // R15
		$error("dpr_ram: port a words do not span the array");
	end
	if ((32'd1 << dpr_addr_w(B_WIDTH)) * B_WIDTH != DPR_CELLS) begin : g_bad_span_b // R15
		$error("dpr_ram: port b words do not span the array");
	end

	// the cell array is one packed vector so either port can cut any width from it
	typedef struct packed {
		logic [DPR_CELLS-1:0] cells; // stored bits
	} dpr_ram_state_type;

	dpr_ram_state_type st_ff;
	dpr_ram_state_type nxt_st;
	logic [4095:0] a_mask; // cells port a writes this edge
	logic [4095:0] a_bits; // data placed on those cells
	logic [4095:0] b_mask; // cells port b writes this edge
	logic [4095:0] b_bits; // data placed on those cells
	logic [4095:0] after_a; // array with port a's write applied

	// port a: own width, mode, enable and address
	dpr_port #(
		.WIDTH(A_WIDTH),
		.MODE(A_MODE)
	) u_port_a (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(a_en),
		.we(a_we),
		.addr(a_addr),
		.write_data_in(a_write_data_in),
		.read_data(a_read_data),
		.cells(st_ff.cells),
		.wr_mask(a_mask),
		.wr_bits(a_bits)
	); // R8 R2

	// port b: same logic, nothing shared with port a but clock, reset and the array
	dpr_port #(
		.WIDTH(B_WIDTH),
		.MODE(B_MODE)
	) u_port_b (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.en(b_en),
		.we(b_we),
		.addr(b_addr),
		.write_data_in(b_write_data_in),
		.read_data(b_read_data),
		.cells(st_ff.cells),
		.wr_mask(b_mask),
		.wr_bits(b_bits)
	); // R8 R2

	// notes for users of this block
	// - both ports run on core_clk here; the ports are otherwise free of each
	//   other, so any mix of reads, writes and idle cycles is legal every edge
	// - a port of width w addresses word k as cells k*w up to k*w+w-1, bit 0
	//   of the word being the lowest cell, so ports of unequal width share data
	// - writes from both ports into one cell in the same edge leave that cell
	//   undefined for the user; the logic below happens to keep port b's bits
	// - a port reading cells that the other port writes in the same edge gets
	//   the old contents, which the user must likewise treat as undefined;
	//   the write itself always lands
	// - there is no arbitration and no stall: a clash costs data, never time,
	//   which keeps both ports single-edge at the price of user discipline
	// - reset clears the whole array in one edge, since every cell is a plain
	//   register; a large array pays for that in reset fan-out

	// merge both ports' writes into the next array value
	// no arbitration: a same-cell clash simply lets port b's bits land last,
	// which is one legal outcome of contents that the user must treat as undefined
	always_comb begin
		nxt_st = st_ff;
		after_a = (st_ff.cells & ~a_mask) | (a_bits & a_mask); // R1 R8
		nxt_st.cells = (after_a & ~b_mask) | (b_bits & b_mask); // R1 R8 R13
	end

	// the array is a plain register set; a reader of a cell being written
	// in the same edge sees the old contents, while the write itself lands
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff <= '{cells: DPR_CELL_RST};
		end else begin
			st_ff <= nxt_st; // R9 R14
		end
	end

	// helper: which writes happened, for the checks below
	logic a_wr; // port a wrote at this edge
	logic b_wr; // port b wrote at this edge
	logic same_word; // both write masks overlap
	logic [4095:0] a_span; // cells that port a addresses this edge
	logic read_clash; // port a reads cells that port b writes this edge
	always_comb begin
		a_wr = |a_mask;
		b_wr = |b_mask;
		same_word = |(a_mask & b_mask);
		a_span = 4096'(dpr_lane_mask(A_WIDTH)) << (32'(a_addr) * A_WIDTH);
		read_clash = a_en && !a_wr && |(a_span & b_mask);
	end

	// a lone port a write is found in the array afterwards
	store_a_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
		a_wr && !same_word |=> A_WIDTH'(dpr_slice(st_ff.cells, 32'($past(a_addr)), A_WIDTH))
			== $past(a_write_data_in))
		else $error("port a write not stored");
	// a lone port b write is found in the array afterwards
	store_b_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
		b_wr && !same_word |=> B_WIDTH'(dpr_slice(st_ff.cells, 32'($past(b_addr)), B_WIDTH))
			== $past(b_write_data_in))
		else $error("port b write not stored");
	// nothing writes, nothing changes
	array_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
		!a_wr && !b_wr |=> $stable(st_ff.cells))
		else $error("array changed without a write");
	// a write by b leaves a's reading port alone until a acts
	cross_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		b_wr && !a_en |=> $stable(a_read_data))
		else $error("port a output moved on port b write");

	// a write by a leaves b's reading port alone until b acts
	cross_read_b_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
		a_wr && !b_en |=> $stable(b_read_data))
		else $error("port b output moved on port a write");

	// a lone port a write touches no cell outside its own word
	only_a_word_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		a_wr && !b_wr |=> (st_ff.cells & ~$past(a_mask))
			== ($past(st_ff.cells) & ~$past(a_mask)))
		else $error("port a write spilled outside its word");

	// a lone port b write touches no cell outside its own word
	only_b_word_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
		b_wr && !a_wr |=> (st_ff.cells & ~$past(b_mask))
			== ($past(st_ff.cells) & ~$past(b_mask)))
		else $error("port b write spilled outside its word");

	// a read-only port turns a write request into a read, so the array stays put
	ro_no_store_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
		A_MODE == DPR_MODE_RO && a_en && a_we && !b_wr |=> $stable(st_ff.cells))
		else $error("read-only port a changed the array");

	// a write-only port has no read path, so a read request leaves its output
	wo_no_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
		B_MODE == DPR_MODE_WO && b_en && !b_we |=> $stable(b_read_data))
		else $error("write-only port b output moved on a read");

	// port a reading a word that port b writes: the write still lands
	clash_store_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
		read_clash |=> B_WIDTH'(dpr_slice(st_ff.cells, 32'($past(b_addr)), B_WIDTH))
			== $past(b_write_data_in))
		else $error("write lost during a read of the same word");

	// reset empties the array; no disable here so the reset edge itself is seen
	reset_clear_a: assert property (@(posedge core_clk) // R1
		!rst_n |=> st_ff.cells == DPR_CELL_RST)
		else $error("array not cleared by reset");

	// reset brings both outputs to their idle word
	reset_out_a: assert property (@(posedge core_clk) // R10
		!rst_n |=> a_read_data == A_WIDTH'(DPR_OUT_RST)
			&& b_read_data == B_WIDTH'(DPR_OUT_RST))
		else $error("outputs not cleared by reset");

	// both ports write distinct words in one edge
	both_write_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		a_wr && b_wr && !same_word);
	// port b reads, at any address, on the edge after a port a write
	write_then_read_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		a_wr ##1 (b_en && !b_we));
	// same-word clash between the ports
	clash_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		same_word);
	// a read-only port is asked to write
	ro_request_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		A_MODE == DPR_MODE_RO && a_en && a_we);
	// port a reads a word that port b writes in the same edge
	read_clash_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		read_clash);

endmodule : dpr_ram

/* test/dpr_user.sv */
// user-side logic that drives one port of the dual-port cell memory
module dpr_user #(
	parameter int unsigned W = 16,
	parameter int unsigned AW = 8
) (
	// request lines
	output logic en,
	output logic we,
	output logic [AW-1:0] addr,
	output logic [W-1:0] wd
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle and harmless at time zero
	initial begin
		en = 1'b0;
		we = 1'b0;
		addr = '0;
		wd = '0;
	end
	// one request, applied just after a falling edge and held for a whole cycle
	task automatic drive(input logic e, input logic w, input logic [AW-1:0] a, input logic [W-1:0] d);
		en = e;
		we = w;
		// address and data flip while the port is disabled so a stale value can never pass for a sampled one
		addr = e ? a : ~addr;
		wd = e ? d : ~wd;
	endtask : drive
endmodule : dpr_user

/* test/tb_dual_port_block_ram.sv */
// self-checking bench for the dual-port cell memory with ports of unequal width
module tb_dual_port_block_ram;
	timeunit 1ns;
	timeprecision 1ns;
	import dpr_pkg::*;
	localparam int unsigned AWD = 16; // port a lane width
	localparam int unsigned BWD = 4; // port b lane width, differs to exercise pairing
	localparam int unsigned AAW = dpr_addr_w(AWD);
	localparam int unsigned BAW = dpr_addr_w(BWD);
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic a_en, a_we, b_en, b_we;
	logic [AAW-1:0] a_addr;
	logic [BAW-1:0] b_addr;
	logic [AWD-1:0] a_wd, a_read_data, last_a = '0;
	logic [BWD-1:0] b_wd, b_read_data, last_b = '0;
	logic [4095:0] mem_ref = DPR_CELL_RST; // expected cell array
	logic [AWD-1:0] qa[$]; // expected port a outputs, one per edge
	logic [BWD-1:0] qb[$];
	logic [AWD-1:0] a_read_m, last_am = '0; // read-only port a of the mode copy
	logic [BWD-1:0] b_read_m, last_bm = '0; // write-only port b of the mode copy
	logic [4095:0] mem_m = DPR_CELL_RST; // expected cells of the mode copy
	logic [AWD-1:0] qam[$];
	logic [BWD-1:0] qbm[$];
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	dpr_user #(.W(AWD), .AW(AAW)) u_a (.en(a_en), .we(a_we), .addr(a_addr), .wd(a_wd));
	dpr_user #(.W(BWD), .AW(BAW)) u_b (.en(b_en), .we(b_we), .addr(b_addr), .wd(b_wd));
	dpr_ram #(.A_WIDTH(AWD), .B_WIDTH(BWD)) uut (.core_clk(core_clk), .rst_n(rst_n),
		.a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_write_data_in(a_wd),
		.a_read_data(a_read_data), .b_en(b_en), .b_we(b_we), .b_addr(b_addr),
		.b_write_data_in(b_wd), .b_read_data(b_read_data));
	// second copy with a read-only port a and a write-only port b, fed the same requests
	dpr_ram #(.A_WIDTH(AWD), .B_WIDTH(BWD), .A_MODE(DPR_MODE_RO),
		.B_MODE(DPR_MODE_WO)) uut_m (.core_clk(core_clk), .rst_n(rst_n),
		.a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_write_data_in(a_wd),
		.a_read_data(a_read_m), .b_en(b_en), .b_we(b_we), .b_addr(b_addr),
		.b_write_data_in(b_wd), .b_read_data(b_read_m));
	// 20 MHz clock
	always #25 core_clk = ~core_clk;
	// verdict and end of run
	task automatic tally_and_finish();
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// one comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// drive one cycle on both ports and note what each output must show after the edge
	task automatic step(input logic ae, aw, input logic [AAW-1:0] aa, input logic [AWD-1:0] ad,
			input logic be, bw, input logic [BAW-1:0] ba, input logic [BWD-1:0] bd);
		@(negedge core_clk);
		u_a.drive(ae, aw, aa, ad);
		u_b.drive(be, bw, ba, bd);
		if (ae) last_a = aw ? ad : mem_ref[aa*AWD +: AWD];
		if (be) last_b = bw ? bd : mem_ref[ba*BWD +: BWD];
		if (ae) last_am = mem_m[aa*AWD +: AWD];
		if (be && bw) last_bm = bd;
		if (ae && aw) mem_ref[aa*AWD +: AWD] = ad;
		if (be && bw) mem_ref[ba*BWD +: BWD] = bd;
		if (be && bw) mem_m[ba*BWD +: BWD] = bd;
		qa.push_back(last_a);
		qb.push_back(last_b);
		qam.push_back(last_am);
		qbm.push_back(last_bm);
	endtask : step
	// watcher: output settles after each edge, oldest note is its expectation
	always @(posedge core_clk) begin
		if (rst_n && qa.size() > 0) begin
			#1;
			chk(16'(a_read_data), 16'(qa.pop_front()));
			chk(16'(b_read_data), 16'(qb.pop_front()));
			chk(16'(a_read_m), 16'(qam.pop_front()));
			chk(16'(b_read_m), 16'(qbm.pop_front()));
		end
	end
	// hang guard, well above the roughly 820 cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 2000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		logic s;
		void'($urandom(94837));
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		step(1'b1, 1'b0, 8'h03, '0, 1'b1, 1'b0, 10'h258, '0);
		// both ports busy, a in the lower half and b in the upper so no cell collides
		for (int i = 0; i < 400; i++) begin
			step(1'($urandom), 1'($urandom), {1'b0, 7'($urandom)}, 16'($urandom),
				1'($urandom), 1'($urandom), {1'b1, 9'($urandom)}, 4'($urandom));
		end
		// one port at a time over the whole array, so each sees the other's writes
		for (int i = 0; i < 400; i++) begin
			s = 1'($urandom);
			step(s, 1'($urandom), 8'($urandom), 16'($urandom),
				!s, 1'($urandom), 10'($urandom), 4'($urandom));
		end
		step(1'b0, 1'b0, '0, '0, 1'b0, 1'b0, '0, '0);
		step(1'b1, 1'b1, 8'h05, 16'ha5c3, 1'b1, 1'b1, 10'h3f0, 4'h9);
		// port a reads word 5 while port b writes its lowest four cells
		step(1'b1, 1'b0, 8'h05, '0, 1'b1, 1'b1, 10'h014, 4'h6);
		step(1'b1, 1'b0, 8'h05, '0, 1'b0, 1'b0, '0, '0);
		// mid-run reset with both ports idle, then the cleared state is read back
		@(negedge core_clk);
		rst_n = 1'b0;
		u_a.drive(1'b0, 1'b0, '0, '0);
		u_b.drive(1'b0, 1'b0, '0, '0);
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		mem_ref = DPR_CELL_RST;
		mem_m = DPR_CELL_RST;
		last_a = '0;
		last_b = '0;
		last_am = '0;
		last_bm = '0;
		step(1'b0, 1'b0, '0, '0, 1'b0, 1'b0, '0, '0);
		step(1'b1, 1'b0, 8'h05, '0, 1'b1, 1'b0, 10'h3f0, '0);
		repeat (3) @(posedge core_clk);
		tally_and_finish();
	end
endmodule : tb_dual_port_block_ram
